// File: cti_core_ctrl.sv
// instruction timing sequencer with idle and power-down control
//
// Overview of operation
// - executing opcode 01H suspends execution and enters idle.
// - idle ends only on reset or an enabled interrupt request.
// - only external low-active interrupt and timer overflow wake idle.
// - waking interrupt leaves idle and vectors to that source's routine.
// - conventional power-down standby mode remains supported alongside idle.
// - accumulator ALU ops 1 byte 1 cycle, immediate 2 bytes 2 cycles.
// - single-operand accumulator operations take 1 byte 1 cycle.
// - register increment/decrement and indirect increment take 1 byte 1 cycle.
// - branches 2 cycles; direct jump and decrement-branch 2 bytes, indirect 1.
// - conditional jumps take 2 bytes and 2 cycles.
// - call 2 bytes 2 cycles; both returns 1 byte 2 cycles.
// - port/bus i/o 2 cycles; masked 2 bytes, plain 1 byte.
// - expander port operations take 1 byte and 2 cycles.
// - external data moves and page lookups take 1 byte 2 cycles.
// - moves and exchanges 1 byte 1 cycle; immediate loads 2 and 2.
// - timer/counter instructions take 1 byte and 1 cycle.
// - control instructions take 1 byte and 1 cycle.
// - idle select completes in one cycle before idle takes effect.
// - in idle, oscillator, timer and interrupt inputs keep running.
// - external interrupt disabled after every reset until re-enabled.
`timescale 1ns/1ps
module cti_core_ctrl
    import cti_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    // instruction fetch
    input  wire logic [7:0]  opcode_in,
    input  wire logic        opcode_valid_in,
    // interrupt sources
    input  wire logic        ext_irq_n_in,
    input  wire logic        timer_ovf_in,
    // power-down wake (external reset pin path handled by sys_rst_in)
    // status and control outputs
    output logic             fetch_ready_out,
    output logic [1:0]       instr_bytes_out,
    output logic [1:0]       instr_cycles_out,
    output logic             instr_done_out,
    output logic             idle_out,
    output logic             power_down_out,
    output logic             vector_load_out,
    output logic [11:0]      vector_addr_out,
    output logic             ext_irq_en_out,
    output logic             timer_irq_en_out,
    output logic             mcyc_end_out
);
    logic       mcyc;
    logic [1:0] dec_bytes;
    logic [1:0] dec_cycles;
    cti_state_t state_reg;
    cti_state_t state_next;
    logic [1:0] cyc_left_reg;
    logic [1:0] cyc_left_next;
    logic [1:0] bytes_reg;
    logic [1:0] cycles_reg;
    logic [7:0] op_reg;
    logic       ext_en_reg;
    logic       tmr_en_reg;
    logic       ext_en_next;
    logic       tmr_en_next;
    logic       tmr_pend_reg;
    logic [1:0] irq_low_cnt_reg;
    logic [1:0] irq_low_cnt_next;
    logic       done_next;
    logic       vload_next;
    logic [11:0] vaddr_next;

    cti_mcyc_gen u_mcyc
    (
        .clk_sys_in   (clk_sys_in),
        .sys_rst_in   (sys_rst_in),
        .mcyc_end_out (mcyc)
    );

    cti_len_decode u_dec
    (
        .opcode_in  (opcode_in),
        .bytes_out  (dec_bytes),
        .cycles_out (dec_cycles)
    );

    // the machine cycle counter and interrupt sampling never stop, even in idle
    wire take      = (state_reg == CTI_ST_RUN) && opcode_valid_in && mcyc;
    wire last_cyc  = (state_reg == CTI_ST_EXEC) && mcyc && (cyc_left_reg == 2'h1);
    wire op_idle   = (op_reg == CTI_OP_IDLE);
    wire op_pdn    = (op_reg == CTI_OP_PWR_DOWN);
    // level is qualified over machine cycles so a short glitch does not wake
    wire ext_req   = (irq_low_cnt_reg == CTI_IRQ_HOLD_LAST) && !ext_irq_n_in;
    wire ext_wake  = ext_req && ext_en_reg;
    wire tmr_wake  = tmr_pend_reg && tmr_en_reg;
    wire any_wake  = ext_wake || tmr_wake;

    assign irq_low_cnt_next = ext_irq_n_in ? 2'h0 :
        ((mcyc && irq_low_cnt_reg != CTI_IRQ_HOLD_LAST) ? 2'(irq_low_cnt_reg + 2'h1) : irq_low_cnt_reg);

    assign ext_en_next = (last_cyc && op_reg == CTI_OP_EN_I) ? 1'b1 :
                         (last_cyc && op_reg == CTI_OP_DIS_I) ? 1'b0 : ext_en_reg;
    assign tmr_en_next = (last_cyc && op_reg == CTI_OP_TMR_IRQ_EN) ? 1'b1 :
                         (last_cyc && op_reg == CTI_OP_TMR_IRQ_DIS) ? 1'b0 : tmr_en_reg;

    assign cyc_left_next = take ? dec_cycles :
                           ((state_reg == CTI_ST_EXEC) && mcyc) ? 2'(cyc_left_reg - 2'h1) : cyc_left_reg;

    // external vector wins when both wake in the same cycle
    assign vaddr_next = ext_wake ? CTI_VEC_EXT : CTI_VEC_TIMER;
    assign vload_next = (state_reg == CTI_ST_IDLE) && any_wake;
    assign done_next  = last_cyc;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CTI_ST_RUN:
            begin
                if (take)
                    state_next = CTI_ST_EXEC;
            end
            CTI_ST_EXEC:
            begin
                // idle select retires its one cycle first, then idle begins
                if (last_cyc && op_idle)
                    state_next = CTI_ST_IDLE;
                else if (last_cyc && op_pdn)
                    state_next = CTI_ST_PDN;
                else if (last_cyc)
                    state_next = CTI_ST_RUN;
            end
            CTI_ST_IDLE:
            begin
                if (any_wake)
                    state_next = CTI_ST_RUN;
            end
            CTI_ST_PDN:
            begin
                // standby is left only through reset
                state_next = CTI_ST_PDN;
            end
            default:
            begin
                state_next = CTI_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            state_reg    <= CTI_ST_RUN;
            cyc_left_reg <= 2'h0;
            op_reg       <= CTI_OP_NOP;
            bytes_reg    <= CTI_LEN_ONE;
            cycles_reg   <= CTI_LEN_ONE;
        end
        else
        begin
            state_reg    <= state_next;
            cyc_left_reg <= cyc_left_next;
            if (take)
            begin
                op_reg     <= opcode_in;
                bytes_reg  <= dec_bytes;
                cycles_reg <= dec_cycles;
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            ext_en_reg      <= 1'b0;
            tmr_en_reg      <= 1'b0;
            tmr_pend_reg    <= 1'b0;
            irq_low_cnt_reg <= 2'h0;
        end
        else
        begin
            ext_en_reg      <= ext_en_next;
            tmr_en_reg      <= tmr_en_next;
            irq_low_cnt_reg <= irq_low_cnt_next;
            // a new overflow wins over the clear taken by a timer wake
            tmr_pend_reg    <= timer_ovf_in || (tmr_pend_reg && !(vload_next && !ext_wake));
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            fetch_ready_out  <= 1'b0;
            instr_bytes_out  <= CTI_LEN_ONE;
            instr_cycles_out <= CTI_LEN_ONE;
            instr_done_out   <= 1'b0;
            idle_out         <= 1'b0;
            power_down_out   <= 1'b0;
            vector_load_out  <= 1'b0;
            vector_addr_out  <= CTI_VEC_RESET;
            ext_irq_en_out   <= 1'b0;
            timer_irq_en_out <= 1'b0;
            mcyc_end_out     <= 1'b0;
        end
        else
        begin
            fetch_ready_out  <= (state_next == CTI_ST_RUN);
            instr_bytes_out  <= bytes_reg;
            instr_cycles_out <= cycles_reg;
            instr_done_out   <= done_next;
            idle_out         <= (state_next == CTI_ST_IDLE);
            power_down_out   <= (state_next == CTI_ST_PDN);
            vector_load_out  <= vload_next;
            if (vload_next)
                vector_addr_out <= vaddr_next;
            ext_irq_en_out   <= ext_en_next;
            timer_irq_en_out <= tmr_en_next;
            mcyc_end_out     <= mcyc;
        end
    end
endmodule

// File: cti_core_ctrl_chk.sv
// checker for the instruction timing and idle control block
`timescale 1ns/1ps
module cti_core_ctrl_chk
    import cti_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    // fetch and interrupts
    input wire logic [7:0]  opcode_in,
    input wire logic        opcode_valid_in,
    input wire logic        ext_irq_n_in,
    input wire logic        timer_ovf_in,
    // status outputs
    input wire logic        fetch_ready_out,
    input wire logic [1:0]  instr_bytes_out,
    input wire logic [1:0]  instr_cycles_out,
    input wire logic        instr_done_out,
    input wire logic        idle_out,
    input wire logic        power_down_out,
    input wire logic        vector_load_out,
    input wire logic [11:0] vector_addr_out,
    input wire logic        ext_irq_en_out,
    input wire logic        timer_irq_en_out,
    input wire logic        mcyc_end_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    // the strobe lags the internal take edge by one clock
    wire logic idle_req = opcode_valid_in && fetch_ready_out && (opcode_in == CTI_OP_IDLE);

    a_mcyc_period: assert property (mcyc_end_out |-> ##15 mcyc_end_out)
        else $error("strobe period wrong");
    a_mcyc_gap: assert property (mcyc_end_out |=> !mcyc_end_out [*8])
        else $error("strobe repeats early");
    a_idle_entry: assert property (idle_req ##1 mcyc_end_out |-> ##[15:17] idle_out)
        else $error("idle not entered");
    a_idle_length: assert property (idle_req ##1 mcyc_end_out |-> ##2
        (instr_bytes_out == CTI_LEN_ONE && instr_cycles_out == CTI_LEN_ONE))
        else $error("idle select length wrong");
    a_idle_no_fetch: assert property (idle_out |-> !fetch_ready_out)
        else $error("fetch while idle");
    a_idle_hold: assert property (idle_out && !ext_irq_en_out && !timer_irq_en_out |=> idle_out)
        else $error("idle left with no enabled source");
    a_wake_source: assert property (vector_load_out |->
        (vector_addr_out == CTI_VEC_EXT && $past(ext_irq_en_out)) ||
        (vector_addr_out == CTI_VEC_TIMER && $past(timer_irq_en_out)))
        else $error("wake from unknown or disabled source");
    a_wake_exit: assert property ($fell(idle_out) |-> vector_load_out && fetch_ready_out)
        else $error("idle exit without vector");
    a_wake_from_idle: assert property (vector_load_out |-> $past(idle_out))
        else $error("vector outside idle");
    a_pdn_hold: assert property (power_down_out |=> power_down_out)
        else $error("power down left without reset");
    a_ext_off_reset: assert property ($fell(sys_rst_in) |-> !ext_irq_en_out)
        else $error("external interrupt enabled after reset");
endmodule

// File: cti_core_ctrl_test.sv
// self-checking testbench for the instruction timing and idle control block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module cti_core_ctrl_test
    import cti_pkg::*;
;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [7:0]  opcode_in = 8'h00;
    logic        opcode_valid_in = 1'b0;
    logic        ext_irq_n_in = 1'b1;
    logic        timer_ovf_in = 1'b0;
    logic        fetch_ready_out, instr_done_out, idle_out, power_down_out, vector_load_out;
    logic        ext_irq_en_out, timer_irq_en_out, mcyc_end_out;
    logic [1:0]  instr_bytes_out, instr_cycles_out;
    logic [11:0] vector_addr_out;
    int          bad_count = 0;
    int          check_count = 0;

    cti_core_ctrl uut (.clk_sys_in, .sys_rst_in, .opcode_in, .opcode_valid_in, .ext_irq_n_in, .timer_ovf_in,
        .fetch_ready_out, .instr_bytes_out, .instr_cycles_out, .instr_done_out, .idle_out, .power_down_out,
        .vector_load_out, .vector_addr_out, .ext_irq_en_out, .timer_irq_en_out, .mcyc_end_out);

    always #25 clk_sys_in = ~clk_sys_in;

    function automatic logic pick(input int k);
        case (k)
            0: return fetch_ready_out;
            1: return instr_done_out;
            2: return vector_load_out;
            default: return power_down_out;
        endcase
    endfunction

    // called just after an edge; n counts the edges waited
    task automatic wait_for(input int k, input logic lvl, input int lim, output int n);
        n = 0;
        while (pick(k) !== lvl && n < lim)
        begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        if (n >= lim)
        begin
            bad_count++;
            $display("ERROR %0t wait on %0d timed out", $time, k);
        end
    endtask

    task automatic do_reset();
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        #1;
    endtask

    // valid is held until the block shows it took the opcode
    task automatic issue(input logic [7:0] op);
        int n;
        wait_for(0, 1'b1, 40, n);
        @(posedge clk_sys_in);
        opcode_in <= op;
        opcode_valid_in <= 1'b1;
        #1;
        wait_for(0, 1'b0, 40, n);
        @(posedge clk_sys_in);
        opcode_valid_in <= 1'b0;
        #1;
    endtask

    task automatic exec(input logic [7:0] op, input logic [1:0] nb, input logic [1:0] nc);
        int n;
        issue(op);
        wait_for(1, 1'b1, 80, n);
        `CHK(n + 1, 15 * int'(nc))
        `CHK(instr_bytes_out, nb)
        `CHK(instr_cycles_out, nc)
    endtask

    task automatic ext_low(input int len);
        @(posedge clk_sys_in);
        ext_irq_n_in <= 1'b0;
        repeat (len) @(posedge clk_sys_in);
        ext_irq_n_in <= 1'b1;
        #1;
    endtask

    task automatic table_test();
        // packed as bytes in [3:2], cycles in [1:0]
        logic [7:0] ops [17] = '{8'h03, 8'h68, 8'h04, 8'h14, 8'hB3, 8'h83, 8'hE8,
                                 8'h16, 8'h80, 8'hA3, 8'h0C, 8'h08, 8'h88, 8'h00,
                                 8'h42, 8'h93, 8'hB8};
        logic [3:0] lens [17] = '{4'hA, 4'h5, 4'hA, 4'hA, 4'h6, 4'h6, 4'hA,
                                  4'hA, 4'h6, 4'h6, 4'h6, 4'h6, 4'hA, 4'h5,
                                  4'h5, 4'h6, 4'hA};
        foreach (ops[i])
            exec(ops[i], lens[i][3:2], lens[i][1:0]);
    endtask

    task automatic idle_masked_test();
        exec(CTI_OP_IDLE, CTI_LEN_ONE, CTI_LEN_ONE);
        `CHK(idle_out, 1'b1)
        `CHK(fetch_ready_out, 1'b0)
        @(posedge clk_sys_in);
        timer_ovf_in <= 1'b1;
        @(posedge clk_sys_in);
        timer_ovf_in <= 1'b0;
        ext_low(60);
        repeat (20) @(posedge clk_sys_in);
        #1;
        `CHK(idle_out, 1'b1)
        do_reset();
        `CHK(idle_out, 1'b0)
    endtask

    task automatic wake_test();
        int n;
        exec(CTI_OP_EN_I, CTI_LEN_ONE, CTI_LEN_ONE);
        `CHK(ext_irq_en_out, 1'b1)
        exec(CTI_OP_IDLE, CTI_LEN_ONE, CTI_LEN_ONE);
        // spans only one strobe and waking needs two, so it must not wake
        ext_low(20);
        repeat (20) @(posedge clk_sys_in);
        #1;
        `CHK(idle_out, 1'b1)
        @(posedge clk_sys_in);
        ext_irq_n_in <= 1'b0;
        #1;
        wait_for(2, 1'b1, 80, n);
        `CHK(vector_addr_out, CTI_VEC_EXT)
        `CHK(idle_out, 1'b0)
        // the requester keeps the pin low for three full machine cycles in all
        repeat (30) @(posedge clk_sys_in);
        ext_irq_n_in <= 1'b1;
        #1;
        exec(CTI_OP_TMR_IRQ_EN, CTI_LEN_ONE, CTI_LEN_ONE);
        `CHK(timer_irq_en_out, 1'b1)
        exec(CTI_OP_IDLE, CTI_LEN_ONE, CTI_LEN_ONE);
        @(posedge clk_sys_in);
        timer_ovf_in <= 1'b1;
        @(posedge clk_sys_in);
        timer_ovf_in <= 1'b0;
        #1;
        wait_for(2, 1'b1, 40, n);
        `CHK(vector_addr_out, CTI_VEC_TIMER)
        `CHK(idle_out, 1'b0)
    endtask

    task automatic power_down_test();
        int n;
        issue(CTI_OP_PWR_DOWN);
        wait_for(3, 1'b1, 60, n);
        ext_low(60);
        `CHK(power_down_out, 1'b1)
        do_reset();
        `CHK(power_down_out, 1'b0)
        `CHK(ext_irq_en_out, 1'b0)
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        #1;
        `CHK(ext_irq_en_out, 1'b0)
        `CHK(vector_addr_out, CTI_VEC_RESET)
        table_test();
        idle_masked_test();
        wake_test();
        power_down_test();
        complete_run();
    end

    // the whole run needs well under two thousand clocks
    initial
    begin
        #1000000;
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end
endmodule

bind cti_core_ctrl cti_core_ctrl_chk chk (.clk_sys_in, .sys_rst_in, .opcode_in, .opcode_valid_in, .ext_irq_n_in,
    .timer_ovf_in, .fetch_ready_out, .instr_bytes_out, .instr_cycles_out, .instr_done_out, .idle_out,
    .power_down_out, .vector_load_out, .vector_addr_out, .ext_irq_en_out, .timer_irq_en_out, .mcyc_end_out);

// File: cti_len_decode.sv
// opcode to byte length and machine cycle count decoder
`timescale 1ns/1ps
module cti_len_decode
    import cti_pkg::*;
(
    // opcode
    input  wire logic [7:0] opcode_in,
    // decoded length
    output logic [1:0]      bytes_out,
    output logic [1:0]      cycles_out
);
    // low nibble of the opcode groups the encoding families
    wire [3:0] lo = opcode_in[3:0];
    wire [3:0] hi = opcode_in[7:4];
    // accumulator and data move immediates: x3 column
    // rows 8 and 9 of this column are the returns, which carry no operand byte
    wire imm_acc   = (lo == 4'h3) && (hi inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'hD});
    // row B also holds the indirect jump and flag ops, so only the load columns count
    wire imm_reg   = (hi == 4'hB) && (lo[3] || (lo[3:1] == 3'h0));
    wire jmp_dir   = (lo == 4'h4) && !hi[0];
    wire call_dir  = (lo == 4'h4) && hi[0];
    wire dec_and_branch = (hi == 4'hE) && opcode_in[3];
    wire indirect_jump  = (opcode_in == 8'hB3);
    // bit tests sit in odd rows of column 2; even rows there are one-cycle moves except 02H, a two-cycle plain i/o
    wire cond_jmp  = (lo == 4'h6) || ((lo == 4'h2) && hi[0]);
    wire ret_any   = (opcode_in == 8'h83) || (opcode_in == 8'h93);
    wire io_mask   = (lo inside {4'h8, 4'h9, 4'hA}) && (hi inside {4'h8, 4'h9});
    wire io_plain  = ((lo inside {4'h8, 4'h9, 4'hA}) && (hi inside {4'h0, 4'h3}))
                  || (opcode_in == 8'h02);
    wire expander  = (lo inside {4'hC, 4'hD, 4'hE, 4'hF}) && (hi inside {4'h0, 4'h3, 4'h8, 4'h9});
    wire ext_or_lookup = (opcode_in inside {8'h80, 8'h81, 8'h90, 8'h91, 8'hA3, 8'hE3});
    wire two_byte  = imm_acc || imm_reg || jmp_dir || call_dir || dec_and_branch || cond_jmp || io_mask;
    wire two_cyc   = two_byte || indirect_jump || ret_any || io_plain || expander || ext_or_lookup;
    // everything else (alu reg, flags, timer, control, idle select) is one byte one cycle
    assign bytes_out  = two_byte ? CTI_LEN_TWO : CTI_LEN_ONE;
    assign cycles_out = two_cyc ? CTI_LEN_TWO : CTI_LEN_ONE;
endmodule

// File: cti_mcyc_gen.sv
// machine cycle strobe generator, one pulse every fifteen oscillator periods
`timescale 1ns/1ps
module cti_mcyc_gen
    import cti_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic sys_rst_in,
    // strobe
    output logic      mcyc_end_out
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       end_next;
    assign end_next = (cnt_reg == CTI_MCYC_LAST);
    assign cnt_next = end_next ? 4'h0 : 4'(cnt_reg + 4'h1);
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            cnt_reg      <= 4'h0;
            mcyc_end_out <= 1'b0;
        end
        else
        begin
            cnt_reg      <= cnt_next;
            mcyc_end_out <= end_next;
        end
    end
endmodule

// File: cti_pkg.sv
// package: constants for instruction timing decoder and idle control
package cti_pkg;
    localparam logic [7:0] CTI_OP_IDLE       = 8'h01;
    localparam logic [7:0] CTI_OP_NOP        = 8'h00;
    localparam logic [7:0] CTI_OP_EN_I       = 8'h05;
    localparam logic [7:0] CTI_OP_DIS_I      = 8'h15;
    localparam logic [7:0] CTI_OP_TMR_IRQ_EN  = 8'h25;
    localparam logic [7:0] CTI_OP_TMR_IRQ_DIS = 8'h35;
    localparam logic [7:0] CTI_OP_PWR_DOWN   = 8'hFF;
    localparam int CTI_OSC_PER_MCYC          = 15;
    localparam logic [3:0] CTI_MCYC_LAST     = 4'(CTI_OSC_PER_MCYC - 1);
    localparam logic [11:0] CTI_VEC_RESET    = 12'h000;
    localparam logic [11:0] CTI_VEC_EXT      = 12'h003;
    localparam logic [11:0] CTI_VEC_TIMER    = 12'h007;
    localparam logic [1:0] CTI_LEN_ONE       = 2'h1;
    localparam logic [1:0] CTI_LEN_TWO       = 2'h2;
    localparam int CTI_IRQ_LOW_MCYC          = 3;
    localparam logic [1:0] CTI_IRQ_HOLD_LAST = 2'(CTI_IRQ_LOW_MCYC - 1);
    typedef enum logic [3:0] {
        CTI_ST_RUN  = 4'h1,
        CTI_ST_EXEC = 4'h2,
        CTI_ST_IDLE = 4'h4,
        CTI_ST_PDN  = 4'h8
    } cti_state_t;
endpackage
